//--- src/hocc_pkg.sv
// constants, types and helpers of the hdlc overhead channel controller
package hocc_pkg;
    localparam logic [7:0] A_CTRL = 8'h50;
    localparam logic [7:0] A_WMSEL = 8'h51;
    localparam logic [7:0] A_LIVE = 8'h54;
    localparam logic [7:0] A_LATCH = 8'h55;
    localparam logic [7:0] A_IE = 8'h56;
    localparam logic [7:0] A_INFO = 8'h57;
    localparam logic [7:0] A_RXD = 8'h5C;
    localparam logic [7:0] A_RXT = 8'h5D;
    localparam logic [7:0] A_TXD = 8'h5E;
    localparam logic [7:0] A_TXT = 8'h5F;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] WMSEL_RST = 8'h00;
    localparam logic [7:0] IE_RST = 8'h00;
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [7:0] WMSEL_MASK = 8'h77;
    // control bits
    localparam int C_FCS_DEF = 0;
    localparam int C_FCS_INV = 1;
    localparam int C_STUFF_DEF = 2;
    localparam int C_FILL_SEL = 3;
    localparam int C_TX_INV = 4;
    localparam int C_RX_INV = 5;
    localparam int C_TX_RST = 6;
    localparam int C_RX_RST = 7;
    // latched status bits
    localparam int S_TX_END = 0;
    localparam int S_TX_UDR = 1;
    localparam int S_TX_LOW = 2;
    localparam int S_RX_HIGH = 3;
    localparam int S_RX_ABT = 4;
    localparam int S_RX_START = 5;
    localparam int S_RX_END = 6;
    localparam int S_RX_OVR = 7;
    // live and info bits
    localparam int L_TX_LOW = 2;
    localparam int L_RX_HIGH = 3;
    localparam int I_TX_EMPTY = 4;
    localparam int I_RX_EMPTY = 5;
    localparam logic [7:0] FLAG_BYTE = 8'h7E;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [7:0] ABORT_BYTE = 8'hFE;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_GOOD = 16'hF0B8;
    localparam logic [1:0] PS_OK = 2'h0;
    localparam logic [1:0] PS_CRC_ERR = 2'h1;
    localparam logic [1:0] PS_ABORT = 2'h2;
    localparam logic [1:0] PS_BAD_LEN = 2'h3;
    localparam logic [2:0] ONES_STUFF = 3'h5;
    localparam logic [2:0] ONES_FLAG = 3'h6;
    localparam int TX_START_MIN = 2;
    localparam logic [8:0] WM_BASE = 9'h010;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hocc_host_req_t;

    typedef struct packed {
        logic [1:0] ps;
        logic last;
        logic first;
        logic [7:0] data;
    } hocc_rx_entry_t;

    typedef struct packed {
        logic eom;
        logic [7:0] data;
    } hocc_tx_entry_t;

    typedef enum logic [1:0] {
        RX_HUNT = 2'b00, RX_ARMED = 2'b01, RX_DATA = 2'b10
    } hocc_rx_state_t;

    typedef enum logic [2:0] {
        TX_ABORT = 3'b000, TX_FILL = 3'b001, TX_OPEN = 3'b010, TX_DATA = 3'b011,
        TX_FCS0 = 3'b100, TX_FCS1 = 3'b101, TX_CLOSE = 3'b110, TX_GAP = 3'b111
    } hocc_tx_state_t;

    // watermark bytes: 16 + 32 * code
    function automatic logic [8:0] hocc_wm(input logic [2:0] sel);
        return WM_BASE + {1'b0, sel, 5'h00};
    endfunction

    // one lsb-first step of the ccitt crc
    function automatic logic [15:0] hocc_crc(input logic [15:0] c, input logic b);
        return (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
    endfunction
endpackage

//--- src/hocc_top.sv
// hdlc overhead channel controller: registers, fifos, receiver, transmitter
`timescale 1ns/1ps
module hocc_top
    import hocc_pkg::*;
#(
    parameter int FIFO_DEPTH = 256
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire hocc_host_req_t host_req,
    input wire logic irq_block_en,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    input wire logic tx_bit_req,
    output logic [7:0] host_rdata,
    output logic irq_req,
    output logic tx_bit
);
    localparam int AW = $clog2(FIFO_DEPTH);
    localparam int CW = AW + 1;

    logic [1:0] rst_pipe;
    logic rst_n;
    logic [7:0] ctrl, wmsel, ie, lat, st_set;
    logic wr_lat, rx_flush, tx_flush, rx_pop, tx_push;
    logic tx_low_q, rx_high_q;
    hocc_rx_entry_t rx_mem [FIFO_DEPTH];
    hocc_rx_entry_t rx_push_ent, rx_head;
    logic [AW-1:0] rx_wp, rx_rp;
    logic [CW-1:0] rx_cnt;
    logic rx_push, rx_full, rx_empty, rx_store, rx_blocked, rx_evt_ovr;
    logic rx_evt_start, rx_evt_end, rx_evt_abort;
    hocc_rx_state_t r_state;
    logic [2:0] r_ones, r_pn, r_bitn;
    logic [6:0] r_pend;
    logic [7:0] r_acc, r_h0, r_h1, r_h2, r_byte;
    logic [1:0] r_nb, r_stat;
    logic [15:0] r_crc;
    logic r_first, r_drop, r_b, r_ev, r_flag, r_abort, r_in, r_rel, r_close;
    hocc_tx_entry_t tx_mem [FIFO_DEPTH];
    hocc_tx_entry_t tx_head;
    logic [AW-1:0] tx_wp, tx_rp;
    logic [CW-1:0] tx_cnt;
    logic [3:0] tx_lvl;
    logic tx_eom_pend, tx_pop, tx_evt_end, tx_evt_udr;
    hocc_tx_state_t t_state;
    logic [7:0] t_sh, t_fcs_hi, t_fill;
    logic [2:0] t_bitn, t_ones;
    logic [15:0] t_crc, t_crc_nx, t_fcs;
    logic t_eom, t_stuff, t_bnd, t_go, t_data_ph;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // reset release through two flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // host strobes
    assign wr_lat = host_req.wr && host_req.addr == A_LATCH;
    assign tx_flush = host_req.wr && host_req.addr == A_CTRL
        && host_req.wdata[C_TX_RST] && !ctrl[C_TX_RST];
    assign rx_flush = host_req.wr && host_req.addr == A_CTRL
        && host_req.wdata[C_RX_RST] && !ctrl[C_RX_RST];
    assign rx_pop = host_req.rd && host_req.addr == A_RXD && !rx_empty;
    assign tx_push = host_req.wr && host_req.addr == A_TXD && tx_cnt != CW'(FIFO_DEPTH);

    // control registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RST;
            wmsel <= WMSEL_RST;
            ie <= IE_RST;
        end else if (host_req.wr) begin
            if (host_req.addr == A_CTRL) ctrl <= host_req.wdata;
            if (host_req.addr == A_WMSEL) wmsel <= host_req.wdata & WMSEL_MASK;
            if (host_req.addr == A_IE) ie <= host_req.wdata;
        end
    end

    // event sources of the latched flags
    always_comb begin
        st_set = '0;
        st_set[S_TX_END] = tx_evt_end;
        st_set[S_TX_UDR] = tx_evt_udr;
        st_set[S_TX_LOW] = (tx_cnt < CW'(hocc_wm(wmsel[2:0]))) && !tx_low_q;
        st_set[S_RX_HIGH] = (rx_cnt > CW'(hocc_wm(wmsel[6:4]))) && !rx_high_q;
        st_set[S_RX_ABT] = rx_evt_abort;
        st_set[S_RX_START] = rx_evt_start;
        st_set[S_RX_END] = rx_evt_end;
        st_set[S_RX_OVR] = rx_evt_ovr;
    end

    // latched flags, live marks, interrupt request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lat <= LAT_RST;
            tx_low_q <= 1'b0;
            rx_high_q <= 1'b0;
            irq_req <= 1'b0;
        end else begin
            lat <= (lat & ~(wr_lat ? host_req.wdata : 8'h00)) | st_set;
            tx_low_q <= tx_cnt < CW'(hocc_wm(wmsel[2:0]));
            rx_high_q <= rx_cnt > CW'(hocc_wm(wmsel[6:4]));
            irq_req <= irq_block_en && |(lat & ie);
        end
    end

    // read data
    assign rx_head = rx_mem[rx_rp];
    assign tx_lvl = ((tx_cnt >> 4) > CW'(15)) ? 4'hF : tx_cnt[7:4];
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata <= 8'h00;
        end else if (host_req.rd) begin
            case (host_req.addr)
                A_CTRL: host_rdata <= ctrl;
                A_WMSEL: host_rdata <= wmsel;
                A_LIVE: host_rdata <= {4'h0, rx_high_q, tx_low_q, 2'b00};
                A_LATCH: host_rdata <= lat;
                A_IE: host_rdata <= ie;
                A_INFO: host_rdata <= {2'b00, rx_empty, tx_cnt == '0, tx_lvl};
                A_RXD: host_rdata <= rx_head.data;
                A_RXT: host_rdata <= {4'h0, rx_head.ps, rx_head.last, rx_head.first};
                default: host_rdata <= 8'h00;
            endcase
        end
    end

    // receive fifo
    assign rx_full = rx_cnt == CW'(FIFO_DEPTH);
    assign rx_empty = rx_cnt == '0;
    assign rx_store = rx_push && !rx_full && !rx_blocked;
    always_ff @(posedge mclk) begin
        if (rx_store) rx_mem[rx_wp] <= rx_push_ent;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_wp <= '0;
            rx_rp <= '0;
            rx_cnt <= '0;
            rx_blocked <= 1'b0;
            rx_evt_ovr <= 1'b0;
        end else if (rx_flush) begin
            rx_wp <= '0;
            rx_rp <= '0;
            rx_cnt <= '0;
            rx_blocked <= 1'b0;
            rx_evt_ovr <= 1'b0;
        end else begin
            if (rx_store) rx_wp <= rx_wp + 1'b1;
            if (rx_pop) rx_rp <= rx_rp + 1'b1;
            rx_cnt <= rx_cnt + CW'(rx_store) - CW'(rx_pop);
            rx_evt_ovr <= rx_push && rx_full && !rx_blocked;
            if (rx_push && rx_full) rx_blocked <= 1'b1;
            else if (rx_empty) rx_blocked <= 1'b0;
        end
    end

    // receive bit classification
    assign r_b = rx_bit ^ ctrl[C_RX_INV];
    assign r_ev = rx_bit_valid && !rx_flush;
    assign r_flag = r_ev && !r_b && r_ones == ONES_FLAG;
    assign r_abort = r_ev && r_b && r_ones == ONES_FLAG;
    assign r_in = r_ev && r_state != RX_HUNT && !r_flag && !r_abort
        && !(!r_b && r_ones == ONES_STUFF);
    assign r_rel = r_in && r_pn == 3'h7;
    assign r_close = (r_flag || r_abort) && r_state == RX_DATA;
    assign r_byte = {r_pend[0], r_acc[7:1]};
    assign r_stat = r_abort ? PS_ABORT : (r_bitn != 3'h0 ? PS_BAD_LEN
        : (r_crc != CRC_GOOD ? PS_CRC_ERR : PS_OK));

    // flag hunt and seven-bit delay line
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_state <= RX_HUNT;
            r_ones <= 3'h0;
            r_pn <= 3'h0;
            r_pend <= 7'h00;
        end else if (rx_flush) begin
            r_state <= RX_HUNT;
            r_ones <= 3'h0;
            r_pn <= 3'h0;
        end else if (rx_bit_valid) begin
            if (!r_b) r_ones <= 3'h0;
            else if (r_ones != 3'h7) r_ones <= r_ones + 3'h1;
            if (r_flag || r_abort) r_pn <= 3'h0;
            else if (r_in) begin
                r_pend <= {r_b, r_pend[6:1]};
                if (r_pn != 3'h7) r_pn <= r_pn + 3'h1;
            end
            unique case (r_state)
                RX_HUNT: if (r_flag) r_state <= RX_ARMED;
                RX_ARMED: begin
                    if (r_abort) r_state <= RX_HUNT;
                    else if (r_rel) r_state <= RX_DATA;
                end
                RX_DATA: begin
                    if (r_abort) r_state <= RX_HUNT;
                    else if (r_flag) r_state <= RX_ARMED;
                end
                default: r_state <= RX_HUNT;
            endcase
        end
    end

    // byte assembly, crc check, fifo writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_acc <= 8'h00;
            r_bitn <= 3'h0;
            r_nb <= 2'h0;
            r_h0 <= 8'h00;
            r_h1 <= 8'h00;
            r_h2 <= 8'h00;
            r_crc <= CRC_PRESET;
            r_first <= 1'b0;
            r_drop <= 1'b0;
            rx_push <= 1'b0;
            rx_push_ent <= '0;
            rx_evt_start <= 1'b0;
            rx_evt_end <= 1'b0;
            rx_evt_abort <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            rx_evt_start <= 1'b0;
            rx_evt_end <= 1'b0;
            rx_evt_abort <= r_abort && r_state == RX_DATA;
            if (rx_blocked) r_drop <= 1'b1;
            if (r_rel && r_state == RX_ARMED) begin
                r_acc <= r_byte;
                r_bitn <= 3'h1;
                r_nb <= 2'h0;
                r_crc <= hocc_crc(CRC_PRESET, r_pend[0]);
                r_first <= 1'b1;
                r_drop <= rx_blocked;
            end else if (r_rel) begin
                r_acc <= r_byte;
                r_bitn <= r_bitn + 3'h1;
                r_crc <= hocc_crc(r_crc, r_pend[0]);
                if (r_bitn == 3'h7) begin
                    r_h0 <= r_byte;
                    r_h1 <= r_h0;
                    r_h2 <= r_h1;
                    if (r_nb != 2'h3) r_nb <= r_nb + 2'h1;
                    // the two newest bytes may be the fcs, so writes lag
                    if (r_nb == 2'h3 && !r_drop && !rx_blocked) begin
                        rx_push <= 1'b1;
                        rx_push_ent <= {PS_OK, 1'b0, r_first, r_h2};
                        r_first <= 1'b0;
                        rx_evt_start <= r_first;
                    end
                end
            end else if (r_close && r_nb == 2'h3 && !r_drop && !rx_blocked) begin
                rx_push <= 1'b1;
                rx_push_ent <= {r_stat, 1'b1, r_first, r_h2};
                rx_evt_start <= r_first;
                rx_evt_end <= !r_abort;
            end
        end
    end

    // transmit fifo
    assign tx_head = tx_mem[tx_rp];
    always_ff @(posedge mclk) begin
        if (tx_push) tx_mem[tx_wp] <= {tx_eom_pend, host_req.wdata};
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_wp <= '0;
            tx_rp <= '0;
            tx_cnt <= '0;
            tx_eom_pend <= 1'b0;
        end else if (tx_flush) begin
            tx_wp <= '0;
            tx_rp <= '0;
            tx_cnt <= '0;
            tx_eom_pend <= 1'b0;
        end else begin
            if (tx_push) tx_wp <= tx_wp + 1'b1;
            if (tx_pop) tx_rp <= tx_rp + 1'b1;
            tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
            if (host_req.wr && host_req.addr == A_TXT) tx_eom_pend <= host_req.wdata[0];
            else if (tx_push) tx_eom_pend <= 1'b0;
        end
    end

    // transmit serializer helpers
    assign t_stuff = tx_bit_req && !ctrl[C_STUFF_DEF] && t_ones == ONES_STUFF;
    assign t_bnd = tx_bit_req && !t_stuff && t_bitn == 3'h7;
    assign t_crc_nx = hocc_crc(t_crc, t_sh[0]);
    assign t_fcs = ctrl[C_FCS_INV] ? t_crc_nx : ~t_crc_nx;
    assign t_fill = ctrl[C_FILL_SEL] ? IDLE_BYTE : FLAG_BYTE;
    assign t_go = tx_cnt >= CW'(TX_START_MIN);
    assign t_data_ph = t_state == TX_DATA || t_state == TX_FCS0 || t_state == TX_FCS1;

    // transmit byte sequencer and bit output
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            t_state <= TX_ABORT;
            t_sh <= ABORT_BYTE;
            t_bitn <= 3'h0;
            t_ones <= 3'h0;
            t_crc <= CRC_PRESET;
            t_fcs_hi <= 8'h00;
            t_eom <= 1'b0;
            tx_pop <= 1'b0;
            tx_evt_end <= 1'b0;
            tx_evt_udr <= 1'b0;
            tx_bit <= 1'b0;
        end else begin
            tx_pop <= 1'b0;
            tx_evt_end <= 1'b0;
            tx_evt_udr <= 1'b0;
            if (tx_flush) begin
                t_state <= TX_ABORT;
                t_sh <= ABORT_BYTE;
                t_bitn <= 3'h0;
                t_ones <= 3'h0;
            end else if (tx_bit_req) begin
                tx_bit <= (t_stuff ? 1'b0 : t_sh[0]) ^ ctrl[C_TX_INV];
                if (t_stuff) begin
                    t_ones <= 3'h0;
                end else begin
                    if (!(t_data_ph && t_sh[0])) t_ones <= 3'h0;
                    else if (t_ones != 3'h7) t_ones <= t_ones + 3'h1;
                    if (t_state == TX_DATA) t_crc <= t_crc_nx;
                    t_bitn <= t_bitn + 3'h1;
                    t_sh <= {1'b0, t_sh[7:1]};
                end
                if (t_bnd) begin
                    unique case (t_state)
                        TX_ABORT, TX_FILL, TX_GAP: begin
                            t_state <= t_go ? TX_OPEN : TX_FILL;
                            t_sh <= t_go ? FLAG_BYTE : t_fill;
                        end
                        TX_OPEN: begin
                            t_state <= TX_DATA;
                            t_sh <= tx_head.data;
                            t_eom <= tx_head.eom;
                            tx_pop <= 1'b1;
                            t_crc <= CRC_PRESET;
                        end
                        TX_DATA: begin
                            if (t_eom) begin
                                tx_evt_end <= 1'b1;
                                t_state <= ctrl[C_FCS_DEF] ? TX_CLOSE : TX_FCS0;
                                t_sh <= ctrl[C_FCS_DEF] ? FLAG_BYTE : t_fcs[7:0];
                                t_fcs_hi <= t_fcs[15:8];
                            end else if (tx_cnt == '0) begin
                                tx_evt_udr <= 1'b1;
                                tx_evt_end <= 1'b1;
                                t_state <= TX_ABORT;
                                t_sh <= ABORT_BYTE;
                            end else begin
                                t_sh <= tx_head.data;
                                t_eom <= tx_head.eom;
                                tx_pop <= 1'b1;
                            end
                        end
                        TX_FCS0: begin
                            t_state <= TX_FCS1;
                            t_sh <= t_fcs_hi;
                        end
                        TX_FCS1: begin
                            t_state <= TX_CLOSE;
                            t_sh <= FLAG_BYTE;
                        end
                        TX_CLOSE: begin
                            t_state <= TX_GAP;
                            t_sh <= FLAG_BYTE;
                        end
                    endcase
                end
            end
        end
    end

    // checks
    a_rx_flush_empty: assert property (rx_flush |=> rx_empty && r_state == RX_HUNT)
        else $error("rx fifo not emptied by reset");
    a_first_latch: assert property (rx_evt_start |=> lat[S_RX_START])
        else $error("packet start not latched");
    a_close_tag: assert property (r_close && r_nb == 2'h3 && !r_drop && !rx_blocked
        |=> rx_push && rx_push_ent.last)
        else $error("closing entry not tagged last");
    a_ovr_latch: assert property (rx_push && rx_full && !rx_blocked
        |=> ##1 lat[S_RX_OVR] && rx_blocked)
        else $error("overrun not latched");
    a_ovr_hold: assert property (rx_blocked && !rx_empty && !rx_flush |=> rx_blocked)
        else $error("overrun block released early");
    a_abort_code: assert property (rx_push && rx_evt_abort |-> rx_push_ent.ps == PS_ABORT)
        else $error("abort status missing");
    a_rx_empty_bit: assert property (host_req.rd && host_req.addr == A_INFO && rx_empty
        |=> host_rdata[I_RX_EMPTY])
        else $error("rx empty not shown");
    a_tx_flush_abort: assert property (tx_flush |=> t_state == TX_ABORT
        && t_sh == ABORT_BYTE && tx_cnt == '0)
        else $error("tx reset did not queue abort");
    a_tx_start_min: assert property (t_bnd && t_state == TX_FILL && tx_cnt < CW'(TX_START_MIN)
        |=> t_state == TX_FILL)
        else $error("packet started too early");
    a_stuff_zero: assert property (t_stuff |=> tx_bit == $past(ctrl[C_TX_INV]))
        else $error("stuffed bit not zero");
    a_close_gap: assert property (t_bnd && t_state == TX_CLOSE
        |=> t_state == TX_GAP && t_sh == FLAG_BYTE)
        else $error("second flag missing");
    a_underrun_flag: assert property (tx_evt_udr |=> lat[S_TX_UDR] && lat[S_TX_END])
        else $error("underrun not latched");
    a_fcs_defeat: assert property (t_bnd && t_state == TX_DATA && t_eom && ctrl[C_FCS_DEF]
        |=> t_state == TX_CLOSE)
        else $error("fcs sent while defeated");
    a_w1c_clear: assert property (wr_lat && host_req.wdata[S_TX_END] && !st_set[S_TX_END]
        |=> !lat[S_TX_END])
        else $error("write one did not clear");
    a_irq_gate: assert property (irq_req |-> $past(irq_block_en) && $past(|(lat & ie)))
        else $error("interrupt without enable");
    c_rx_end: cover property (rx_evt_end);
    c_rx_ovr: cover property (rx_evt_ovr);
    c_tx_end: cover property (tx_evt_end && !tx_evt_udr);
    c_tx_udr: cover property (tx_evt_udr);
endmodule

//--- tb/hocc_framer_model.sv
// framer overhead bit model: feeds rx bits, pulls tx bits
`timescale 1ns/1ps
module hocc_framer_model (
    input wire logic mclk,
    input wire logic tx_bit,
    output logic rx_bit,
    output logic rx_bit_valid,
    output logic tx_bit_req
);
    int ones = 0;
    int tones = 0;
    initial begin
        rx_bit = 1'b1;
        rx_bit_valid = 1'b0;
        tx_bit_req = 1'b0;
    end
    // one strobed bit; line shows the inverse between strobes
    task automatic put_bit(input logic b);
        @(negedge mclk) rx_bit = b;
        rx_bit_valid = 1'b1;
        @(negedge mclk) rx_bit_valid = 1'b0;
        rx_bit = ~b;
    endtask
    // lsb first, optional zero insertion after five ones
    task automatic put_byte(input logic [7:0] b, input logic stuff);
        for (int i = 0; i < 8; i++) begin
            put_bit(b[i]);
            ones = b[i] ? ones + 1 : 0;
            if (stuff && ones == 5) begin
                put_bit(1'b0);
                ones = 0;
            end
        end
    endtask
    // pull eight tx bits lsb first, dropping the zero that follows five ones
    task automatic get_byte(output logic [7:0] b);
        int i = 0;
        while (i < 8) begin
            @(negedge mclk) tx_bit_req = 1'b1;
            @(negedge mclk) tx_bit_req = 1'b0;
            if (tones == 5 && !tx_bit) begin
                tones = 0;
            end else begin
                b[i] = tx_bit;
                tones = tx_bit ? tones + 1 : 0;
                i++;
            end
        end
    endtask
endmodule

//--- tb/hocc_top_tb.sv
// self-checking bench of the hdlc overhead channel controller
`timescale 1ns/1ps
module hocc_top_tb;
    import hocc_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    hocc_host_req_t host_req = '0;
    logic irq_block_en = 1'b0;
    logic rx_bit, rx_bit_valid, tx_bit_req, tx_bit, irq_req;
    logic [7:0] host_rdata, d;
    logic [15:0] c;
    int n_errors = 0;
    int tests_run = 0;
    always #10 mclk = ~mclk;
    hocc_top uut (.mclk(mclk), .rstn(rstn), .host_req(host_req), .irq_block_en(irq_block_en),
        .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .tx_bit_req(tx_bit_req),
        .host_rdata(host_rdata), .irq_req(irq_req), .tx_bit(tx_bit));
    hocc_framer_model fm (.mclk(mclk), .tx_bit(tx_bit), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .tx_bit_req(tx_bit_req));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // expected fcs: complement of the lsb-first crc over two bytes
    function automatic logic [15:0] fcs16(input logic [15:0] w);
        logic [15:0] r;
        r = CRC_PRESET;
        for (int i = 0; i < 16; i++) r = (r >> 1) ^ ((r[0] ^ w[i]) ? CRC_POLY : 16'h0000);
        return ~r;
    endfunction
    // pull one tx byte from the framer side and compare it
    task automatic pull(input logic [7:0] e);
        fm.get_byte(d);
        check(d, e);
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one-cycle register strobes
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk) host_req = {1'b1, 1'b0, a, v};
        @(negedge mclk) host_req = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk) host_req = {1'b0, 1'b1, a, 8'h00};
        @(negedge mclk) host_req = '0;
        check(host_rdata, exp);
    endtask
    // reset values, empty flags, unmapped read
    task automatic t_reset();
        rd(A_CTRL, 8'h00);
        rd(A_INFO, 8'h30);
        rd(8'h52, 8'h00);
    endtask
    // abort, fill, packet without fcs, stuffed packet with fcs, underrun, tx reset
    task automatic t_tx();
        pull(ABORT_BYTE);
        pull(FLAG_BYTE);
        wr(A_CTRL, 8'h09);
        wr(A_TXD, 8'h12);
        wr(A_TXT, 8'h01);
        wr(A_TXD, 8'h34);
        pull(FLAG_BYTE);
        pull(FLAG_BYTE);
        pull(8'h12);
        pull(8'h34);
        pull(FLAG_BYTE);
        pull(FLAG_BYTE);
        pull(IDLE_BYTE);
        wr(A_CTRL, 8'h00);
        wr(A_TXD, 8'h1F);
        wr(A_TXT, 8'h01);
        wr(A_TXD, 8'h34);
        c = fcs16({8'h34, 8'h1F});
        pull(IDLE_BYTE);
        pull(FLAG_BYTE);
        pull(8'h1F);
        pull(8'h34);
        pull(c[7:0]);
        pull(c[15:8]);
        pull(FLAG_BYTE);
        pull(FLAG_BYTE);
        wr(A_TXD, 8'h55);
        wr(A_TXD, 8'hAA);
        pull(FLAG_BYTE);
        pull(FLAG_BYTE);
        pull(8'h55);
        pull(8'hAA);
        pull(ABORT_BYTE);
        rd(A_LATCH, 8'h07);
        wr(A_CTRL, 8'h40);
        pull(ABORT_BYTE);
        pull(FLAG_BYTE);
    endtask
    // good frame with fcs, stuffing enabled but no zero inserted, then an abort inside a packet
    task automatic t_rx();
        fm.put_byte(FLAG_BYTE, 1'b0);
        fm.put_byte(8'hA5, 1'b1);
        fm.put_byte(8'h3C, 1'b1);
        c = fcs16({8'h3C, 8'hA5});
        fm.put_byte(c[7:0], 1'b1);
        fm.put_byte(c[15:8], 1'b1);
        fm.put_byte(FLAG_BYTE, 1'b0);
        repeat (4) @(negedge mclk);
        rd(A_RXT, 8'h01);
        rd(A_RXD, 8'hA5);
        rd(A_RXT, 8'h02);
        rd(A_RXD, 8'h3C);
        rd(A_INFO, 8'h30);
        wr(A_LATCH, 8'hFF);
        fm.put_byte(FLAG_BYTE, 1'b0);
        fm.put_byte(8'h55, 1'b1);
        fm.put_byte(IDLE_BYTE, 1'b0);
        repeat (4) @(negedge mclk);
        rd(A_IE, 8'h00);
        check({7'h00, irq_req}, 8'h00);
        wr(A_LATCH, 8'h6F);
        rd(A_LATCH, 8'h10);
        wr(A_IE, 8'h10);
        irq_block_en = 1'b1;
        repeat (2) @(negedge mclk);
        check({7'h00, irq_req}, 8'h01);
        wr(A_LATCH, 8'h10);
        repeat (2) @(negedge mclk);
        check({7'h00, irq_req}, 8'h00);
    endtask
    initial begin
        #1ms;
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge mclk);
        @(negedge mclk) rstn = 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_tx();
        t_rx();
        give_verdict();
    end
endmodule
